// file: rtl/sapi_pkg.sv
// Constants and types shared by both ends of the converter parallel interface
//
// Behaviour
// - Host holds write strobe low 25 ns minimum.
// - Conversion starts at write fall, address valid.
// - Conversion mode on first conversion-clock rise.
// - MSB first cycle, LSB on twelfth cycle.
// - Busy falls within 20 ns of write; the converter drops it three clocks (24 ns) after write falls.
// - Busy low whole conversion; result valid rising.
// - Host may latch result on busy rise.
// - Host reads each result right after conversion.
// - Results are straight binary, 000 to FFF.
// - Data bus enabled only while select, read low.
// - Host holds select and read 25 ns.
// - Data valid 25 ns after select, read fall.
// - Data held 25 ns after strobes rise.
// - Read rise with address bit zero high: power-down.
// - Read rise with address bit zero low: wake.
// - Power-down turns off all circuitry; here it only blocks new conversions, reads and wake still work.
// - Power decisions need select low, busy high.
// - Host supplies sixteen clocks per conversion cycle.
`default_nettype none

package sapi_pkg;

    // ------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------
    localparam int unsigned DATA_W      = 12;
    localparam int unsigned CHAN_W      = 2;
    localparam int unsigned BIT_CNT_W   = 4;
    localparam logic [3:0]  BITS_PER_CONV = 4'hc;
    localparam logic [4:0]  CLKS_PER_CONV = 5'h10;
    localparam logic [11:0] CODE_ZERO   = 12'h000;
    localparam logic [11:0] CODE_MID    = 12'h800;
    localparam logic [11:0] CODE_FULL   = 12'hfff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned STROBE_MIN_NS = 25;
    localparam int unsigned BUSY_MAX_NS   = 20;
    localparam int unsigned ACCESS_NS     = 25;
    localparam int unsigned RELINQ_NS     = 25;
    localparam int unsigned CCLK_HALF_NS  = 150;
    localparam int unsigned CCLK_PER_NS   = 500;
    // Least times round up, longest times round down
    localparam int unsigned STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUSY_MAX_CYC   = BUSY_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RELINQ_CYC     = (RELINQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CCLK_HALF_CYC  = (CCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CCLK_PER_CYC   = (CCLK_PER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CCLK_HI_CYC    = CCLK_HALF_CYC;
    localparam int unsigned CCLK_LO_CYC    = CCLK_PER_CYC - CCLK_HALF_CYC;
    localparam int unsigned TCNT_W         = 6;

    typedef enum logic [1:0] {
        SAPI_CMD_CONV,
        SAPI_CMD_SLEEP,
        SAPI_CMD_WAKE
    } sapi_cmd_t;

endpackage : sapi_pkg

`default_nettype wire

// file: rtl/sapi_if.sv
// Parallel pins between host controller and converter
`default_nettype none

interface sapi_if;
    import sapi_pkg::*;

    logic               wr_n;
    logic               cs_n;
    logic               rd_n;
    logic               chan_addr_lo;
    logic               chan_addr_hi;
    logic               conv_clk;
    logic               busy_n;
    logic [DATA_W-1:0]  data_out;
    logic               data_oe_n;
    logic [DATA_W-1:0]  data_bus;

    // Released bus shows the inverse, so a late sample by the host is caught
    assign data_bus = data_oe_n ? ~data_out : data_out;

    modport dev (
        input  wr_n, cs_n, rd_n, chan_addr_lo, chan_addr_hi, conv_clk,
        output busy_n, data_out, data_oe_n
    );
    modport host (
        output wr_n, cs_n, rd_n, chan_addr_lo, chan_addr_hi, conv_clk,
        input  busy_n, data_bus
    );
endinterface : sapi_if

`default_nettype wire

// file: rtl/sapi_dev.sv
// Converter end: conversion sequencer, result bus and power control
`default_nettype none

module sapi_dev
    import sapi_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    sapi_if.dev                     pins,
    input  wire logic [DATA_W-1:0]  analog_code [4],
    output logic                    powered_down,
    output logic [CHAN_W-1:0]       chan_sel
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_q, sync2_q, prev_q;
    logic [5:0] sync1_d, sync2_d, prev_d;
    logic wr_s, cs_s, rd_s, a0_s, a1_s, ck_s;
    logic wr_fall, rd_rise, ck_rise;

    always_comb begin
        sync1_d = {pins.wr_n, pins.cs_n, pins.rd_n, pins.chan_addr_lo,
                   pins.chan_addr_hi, pins.conv_clk};
        sync2_d = sync1_q;
        prev_d  = sync2_q;
        {wr_s, cs_s, rd_s, a0_s, a1_s, ck_s} = sync2_q;
        wr_fall = prev_q[5] & ~wr_s;
        rd_rise = ~prev_q[3] & rd_s;
        ck_rise = ~prev_q[0] & ck_s;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 6'h3e;
            sync2_q <= 6'h3e;
            prev_q  <= 6'h3e;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} sapi_dst_t;
    sapi_dst_t            st_q, st_d;
    logic [BIT_CNT_W-1:0] bit_q, bit_d;
    logic [DATA_W-1:0]    sar_q, sar_d, res_q, res_d;
    logic [CHAN_W-1:0]    ch_q, ch_d;
    logic                 busy_n_q, busy_n_d, pd_q, pd_d;
    logic [DATA_W-1:0]    trial;

    always_comb begin
        st_d     = st_q;
        bit_d    = bit_q;
        sar_d    = sar_q;
        res_d    = res_q;
        ch_d     = ch_q;
        busy_n_d = busy_n_q;
        pd_d     = pd_q;
        trial    = '0;
        case (st_q)
            ST_IDLE: begin
                // start at write fall, never while asleep
                if (wr_fall && !cs_s && !pd_q) begin
                    ch_d     = {a1_s, a0_s};
                    busy_n_d = 1'b0;
                    st_d     = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (ck_rise) begin
                    bit_d = BIT_CNT_W'(DATA_W - 1);
                    sar_d = '0;
                    st_d  = ST_CONV;
                end
            end
            ST_CONV: begin
                // one bit per clock, MSB first
                if (ck_rise) begin
                    trial = sar_q | (DATA_W'(1) << bit_q);
                    sar_d = (analog_code[ch_q] >= trial) ? trial : sar_q;
                    if (bit_q == '0) begin
                        res_d    = (analog_code[ch_q] >= trial) ? trial : sar_q;
                        busy_n_d = 1'b1;
                        st_d     = ST_IDLE;
                    end else begin
                        bit_d = bit_q - 1'b1;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // power decision needs select low, busy high
        if (rd_rise && !cs_s && busy_n_q && st_q == ST_IDLE) begin
            pd_d = a0_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            bit_q    <= '0;
            sar_q    <= '0;
            res_q    <= CODE_ZERO;
            ch_q     <= '0;
            busy_n_q <= 1'b1;
            pd_q     <= 1'b0;
        end else begin
            st_q     <= st_d;
            bit_q    <= bit_d;
            sar_q    <= sar_d;
            res_q    <= res_d;
            ch_q     <= ch_d;
            busy_n_q <= busy_n_d;
            pd_q     <= pd_d;
        end
    end

    // ------------------------------------------------------------
    // Output bus drive
    // ------------------------------------------------------------
    logic                 oe_n_q, oe_n_d;
    logic [DATA_W-1:0]    dout_q, dout_d;
    logic [TCNT_W-1:0]    rel_q, rel_d;

    always_comb begin
        oe_n_d = oe_n_q;
        dout_d = dout_q;
        rel_d  = rel_q;
        if (!cs_s && !rd_s && busy_n_q) begin
            oe_n_d = 1'b0;
            dout_d = res_q;
            rel_d  = TCNT_W'(RELINQ_CYC);
        end else if (rel_q != '0) begin
            rel_d = rel_q - 1'b1;
        end else begin
            oe_n_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_n_q <= 1'b1;
            dout_q <= '0;
            rel_q  <= '0;
        end else begin
            oe_n_q <= oe_n_d;
            dout_q <= dout_d;
            rel_q  <= rel_d;
        end
    end

    // Pin and status outputs straight from registers
    assign pins.busy_n    = busy_n_q;
    assign pins.data_out  = dout_q;
    assign pins.data_oe_n = oe_n_q;
    assign powered_down   = pd_q;
    assign chan_sel       = ch_q;

endmodule : sapi_dev

`default_nettype wire

// file: rtl/sapi_host.sv
// Host end: strobe sequencer, conversion clock and result capture
`default_nettype none

module sapi_host
    import sapi_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    sapi_if.host                    pins,
    input  wire logic               cmd_valid,
    input  wire sapi_cmd_t          cmd,
    input  wire logic [CHAN_W-1:0]  cmd_chan,
    output logic                    cmd_ready,
    output logic                    res_valid,
    output logic [DATA_W-1:0]       res_data,
    input  wire logic               res_ready
);

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    logic              ck_q, ck_d;
    logic [TCNT_W-1:0] ckc_q, ckc_d;
    logic [4:0]        frm_q, frm_d;

    always_comb begin
        ck_d  = ck_q;
        ckc_d = ckc_q - 1'b1;
        if (ckc_q == '0) begin
            ck_d  = ~ck_q;
            ckc_d = ck_q ? TCNT_W'(CCLK_LO_CYC - 1) : TCNT_W'(CCLK_HI_CYC - 1);
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers for busy and data
    // ------------------------------------------------------------
    logic [DATA_W:0] s1_q, s2_q;
    logic            busy_prev_q;
    logic            busy_s, busy_rise;

    always_comb begin
        busy_s    = s2_q[DATA_W];
        busy_rise = busy_s & ~busy_prev_q;
    end

    // ------------------------------------------------------------
    // Strobe sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HS_IDLE, HS_WR, HS_WAIT, HS_RD, HS_REL, HS_PWR
    } sapi_hst_t;
    sapi_hst_t         st_q, st_d;
    logic [TCNT_W-1:0] t_q, t_d;
    logic              wr_n_q, wr_n_d, cs_n_q, cs_n_d, rd_n_q, rd_n_d;
    logic              a0_q, a0_d, a1_q, a1_d;
    logic              push;
    logic [DATA_W-1:0] push_data;
    logic              fifo_ready;
    logic              can_take;

    always_comb begin
        st_d = st_q;
        t_d  = (t_q != '0) ? t_q - 1'b1 : t_q;
        wr_n_d = wr_n_q;
        cs_n_d = cs_n_q;
        rd_n_d = rd_n_q;
        a0_d = a0_q;
        a1_d = a1_q;
        push = 1'b0;
        push_data = s2_q[DATA_W-1:0];
        // sixteen clock rises per conversion cycle
        can_take = busy_s && fifo_ready && (frm_q == CLKS_PER_CONV);
        frm_d = frm_q;
        if (ck_d && !ck_q && (frm_q != CLKS_PER_CONV)) begin
            frm_d = frm_q + 5'h01;
        end
        case (st_q)
            HS_IDLE: begin
                if (cmd_valid && can_take) begin
                    cs_n_d = 1'b0;
                    t_d    = TCNT_W'(STROBE_MIN_CYC);
                    if (cmd == SAPI_CMD_CONV) begin
                        {a1_d, a0_d} = cmd_chan;
                        wr_n_d = 1'b0;
                        frm_d  = 5'h00;
                        st_d   = HS_WR;
                    end else begin
                        a0_d   = (cmd == SAPI_CMD_SLEEP);
                        rd_n_d = 1'b0;
                        st_d   = HS_PWR;
                    end
                end
            end
            HS_WR: begin
                if (t_q == '0) begin
                    wr_n_d = 1'b1;
                    st_d   = HS_WAIT;
                end
            end
            HS_WAIT: begin
                // read as soon as busy rises
                if (busy_rise && fifo_ready) begin
                    rd_n_d = 1'b0;
                    t_d    = TCNT_W'(ACCESS_CYC + 2 * 2);
                    st_d   = HS_RD;
                end
            end
            HS_RD: begin
                if (t_q == '0) begin
                    push   = 1'b1;
                    rd_n_d = 1'b1;
                    cs_n_d = 1'b1;
                    t_d    = TCNT_W'(RELINQ_CYC + 2 * 2);
                    st_d   = HS_REL;
                end
            end
            HS_PWR: begin
                // read rises while select stays low
                if (t_q == '0) begin
                    rd_n_d = 1'b1;
                    t_d    = TCNT_W'(RELINQ_CYC + 2 * 2);
                    st_d   = HS_REL;
                end
            end
            HS_REL: begin
                if (t_q == '0) begin
                    cs_n_d = 1'b1;
                    st_d   = HS_IDLE;
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Two-entry result buffer
    // ------------------------------------------------------------
    logic [DATA_W-1:0] buf_q [2];
    logic [1:0]        cnt_q;
    logic              wp_q, rp_q;
    logic              pop;

    always_comb begin
        fifo_ready = (cnt_q != 2'h2);
        pop        = (cnt_q != 2'h0) && res_ready;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
            ckc_q <= '0;
            frm_q <= CLKS_PER_CONV;
            s1_q <= {1'b1, {DATA_W{1'b0}}};
            s2_q <= {1'b1, {DATA_W{1'b0}}};
            busy_prev_q <= 1'b1;
            st_q <= HS_IDLE;
            t_q <= '0;
            wr_n_q <= 1'b1;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            a0_q <= 1'b0;
            a1_q <= 1'b0;
            cnt_q <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            ck_q <= ck_d;
            ckc_q <= ckc_d;
            frm_q <= frm_d;
            s1_q <= {pins.busy_n, pins.data_bus};
            s2_q <= s1_q;
            busy_prev_q <= busy_s;
            st_q <= st_d;
            t_q <= t_d;
            wr_n_q <= wr_n_d;
            cs_n_q <= cs_n_d;
            rd_n_q <= rd_n_d;
            a0_q <= a0_d;
            a1_q <= a1_d;
            if (push) begin
                buf_q[wp_q] <= push_data;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end

    assign pins.wr_n         = wr_n_q;
    assign pins.cs_n         = cs_n_q;
    assign pins.rd_n         = rd_n_q;
    assign pins.chan_addr_lo = a0_q;
    assign pins.chan_addr_hi = a1_q;
    assign pins.conv_clk     = ck_q;
    assign cmd_ready         = (st_q == HS_IDLE) && can_take;
    assign res_valid         = (cnt_q != 2'h0);
    assign res_data          = buf_q[rp_q];

endmodule : sapi_host

`default_nettype wire

// file: tb/sapi_assertions.sv
// Concurrent checks on the pins between host and converter
`default_nettype none

module sapi_assertions
    import sapi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic chan_addr_lo,
    input wire logic chan_addr_hi,
    input wire logic conv_clk,
    input wire logic busy_n,
    input wire logic data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Conversion clock rises while busy and since write fall, and phase length
    // ------------------------------------------------------------
    logic       cclk_q;
    logic       wr_q;
    logic [4:0] rise_cnt_q;
    logic [4:0] rise_cnt_d;
    logic [5:0] ph_q;
    logic [5:0] ph_d;
    logic [4:0] frm_q;
    logic [4:0] frm_d;

    always_comb begin
        // Cycles in the present clock phase, saturating
        ph_d = (conv_clk != cclk_q) ? 6'h00 : ((ph_q == 6'h3f) ? ph_q : ph_q + 6'h01);
        // Clock rises since the last write fall, saturating
        frm_d = frm_q;
        if (!wr_n && wr_q) begin
            frm_d = 5'h00;
        end else if (conv_clk && !cclk_q && frm_q != 5'h1f) begin
            frm_d = frm_q + 5'h01;
        end
        rise_cnt_d = rise_cnt_q;
        if (busy_n) begin
            rise_cnt_d = 5'h00;
        end else if (conv_clk && !cclk_q) begin
            rise_cnt_d = rise_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cclk_q     <= 1'b0;
            wr_q       <= 1'b1;
            rise_cnt_q <= 5'h00;
            ph_q       <= 6'h3f;
            frm_q      <= 5'h1f;
        end else begin
            cclk_q     <= conv_clk;
            wr_q       <= wr_n;
            rise_cnt_q <= rise_cnt_d;
            ph_q       <= ph_d;
            frm_q      <= frm_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // write strobe width
    AST_WR_WIDTH: assert property (
        $fell(wr_n) |=> !wr_n [*3]) else $error("write strobe too short");
    AST_BUSY_FALL: assert property (
        $fell(wr_n) && !cs_n |-> ##[1:5] !busy_n) else $error("busy late after write");
    AST_BUSY_SEL: assert property (
        $fell(busy_n) |-> !cs_n) else $error("busy fell without select");
    AST_BUSY_BITS: assert property (
        $rose(busy_n) |-> rise_cnt_q inside {5'h0c, 5'h0d})
        else $error("busy rose after wrong clock count");
    AST_NO_DRIVE_BUSY: assert property (
        !busy_n |-> data_oe_n) else $error("bus driven while busy");
    AST_OE_CAUSE: assert property (
        $fell(data_oe_n) |-> !cs_n && !rd_n && busy_n) else $error("bus driven without read");
    AST_OE_ACCESS: assert property (
        (!cs_n && !rd_n && busy_n) [*5] |-> !data_oe_n) else $error("bus not driven in read");
    AST_OE_HOLD: assert property (
        $rose(rd_n) && !data_oe_n |=> !data_oe_n) else $error("bus released too early");
    AST_OE_RELEASE: assert property (
        $rose(rd_n) |-> ##[1:8] data_oe_n) else $error("bus never released");
    AST_RD_WIDTH: assert property (
        $fell(rd_n) |=> (!rd_n && !cs_n) [*3]) else $error("read strobe too short");

    AST_READ_SOON: assert property (
        $rose(busy_n) |-> ##[1:8] !rd_n) else $error("result not read after busy rose");
    AST_CONV_FRAME: assert property (
        $fell(wr_n) |-> frm_q >= CLKS_PER_CONV) else $error("conversion cycle too short");
    AST_CCLK_PHASE: assert property (
        (conv_clk != cclk_q) |-> ph_q >= 6'(CCLK_HALF_CYC - 1))
        else $error("conversion clock phase too short");

    AST_COV_CONV: cover property ($rose(busy_n));
    AST_COV_SLEEP: cover property ($rose(rd_n) && !cs_n && chan_addr_lo && busy_n);
    AST_COV_WAKE: cover property ($rose(rd_n) && !cs_n && !chan_addr_lo && busy_n);
    AST_COV_CH3: cover property ($fell(wr_n) && chan_addr_hi && chan_addr_lo);

endmodule : sapi_assertions

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench joining host and converter ends
`default_nettype none

module tb_top
    import sapi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk;
    logic              rst_n;
    logic              cmd_valid;
    sapi_cmd_t         cmd;
    logic [CHAN_W-1:0] cmd_chan;
    logic              cmd_ready;
    logic              res_valid;
    logic [DATA_W-1:0] res_data;
    logic              res_ready;
    logic [DATA_W-1:0] analog_code [4];
    logic              powered_down;
    logic [CHAN_W-1:0] chan_sel;
    int                n_fail;
    int                n_compared;

    // ------------------------------------------------------------
    // Both ends and the pin checker
    // ------------------------------------------------------------
    sapi_if u_sapi_if ();

    sapi_dev u_sapi_dev (.clk(clk), .rst_n(rst_n), .pins(u_sapi_if.dev),
        .analog_code(analog_code), .powered_down(powered_down), .chan_sel(chan_sel));

    sapi_host u_sapi_host (.clk(clk), .rst_n(rst_n), .pins(u_sapi_if.host),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_chan(cmd_chan), .cmd_ready(cmd_ready),
        .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));

    sapi_assertions u_sapi_assertions (.clk(clk), .rst_n(rst_n), .wr_n(u_sapi_if.wr_n),
        .cs_n(u_sapi_if.cs_n), .rd_n(u_sapi_if.rd_n), .chan_addr_lo(u_sapi_if.chan_addr_lo),
        .chan_addr_hi(u_sapi_if.chan_addr_hi), .conv_clk(u_sapi_if.conv_clk),
        .busy_n(u_sapi_if.busy_n), .data_oe_n(u_sapi_if.data_oe_n));

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("COUNTS compared=%0d failed=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic timeout(input string what);
        n_fail++;
        $display("[FAIL] %s expected handshake seen none", what);
        test_done();
    endtask : timeout

    // Hold the command until the host takes it
    task automatic send(input sapi_cmd_t c, input logic [CHAN_W-1:0] ch);
        int i;
        cmd       <= c;
        cmd_chan  <= ch;
        cmd_valid <= 1'b1;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (cmd_ready === 1'b1) break;
        end
        if (i == 4000) timeout("cmd_ready");
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(posedge clk);
    endtask : send

    // Wait for the buffer head, compare it, then pop it
    task automatic pop(input string what, input logic [DATA_W-1:0] exp);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (res_valid === 1'b1) break;
        end
        if (i == 4000) timeout(what);
        chk(what, exp, res_data);
        chk("busy_n at result", 12'h001, {11'h000, u_sapi_if.busy_n});
        @(posedge clk);
        res_ready <= 1'b1;
        @(posedge clk);
        res_ready <= 1'b0;
    endtask : pop

    task automatic wait_pd(input logic lvl);
        int i;
        for (i = 0; i < 200; i++) begin
            @(negedge clk);
            if (powered_down === lvl) break;
        end
        if (i == 200) timeout("powered_down");
        chk("powered_down", {11'h000, lvl}, {11'h000, powered_down});
        @(posedge clk);
    endtask : wait_pd

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_codes();
        logic [DATA_W-1:0] tbl [8];
        int                r;
        int                ch;
        tbl = '{12'h000, 12'h800, 12'h7ff, 12'hfff, 12'ha5a, 12'h5a5, 12'h001, 12'hffe};
        for (r = 0; r < 2; r++) begin
            for (ch = 0; ch < 4; ch++) begin
                analog_code[ch] <= tbl[4*r+ch];
            end
            for (ch = 0; ch < 4; ch++) begin
                send(SAPI_CMD_CONV, ch[CHAN_W-1:0]);
                pop("res_data", tbl[4*r+ch]);
                chk("chan_sel", {10'h000, ch[1:0]}, {10'h000, chan_sel});
            end
        end
        $display("test_codes done");
    endtask : test_codes

    // Two results wait unread; a third command must be refused
    task automatic test_buffer();
        int i;
        send(SAPI_CMD_CONV, 2'h2);
        send(SAPI_CMD_CONV, 2'h1);
        for (i = 0; i < 1500; i++) begin
            @(negedge clk);
            if (cmd_ready !== 1'b0) break;
        end
        chk("cmd_ready when full", 12'h000, {11'h000, cmd_ready});
        @(posedge clk);
        pop("res_data first", 12'h001);
        pop("res_data second", 12'h5a5);
        $display("test_buffer done");
    endtask : test_buffer

    task automatic test_power();
        send(SAPI_CMD_SLEEP, 2'h1);
        wait_pd(1'b1);
        send(SAPI_CMD_WAKE, 2'h0);
        wait_pd(1'b0);
        send(SAPI_CMD_CONV, 2'h3);
        pop("res_data after wake", 12'hffe);
        $display("test_power done");
    endtask : test_power

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk        = 1'b0;
        rst_n      = 1'b0;
        cmd_valid  = 1'b0;
        cmd        = SAPI_CMD_CONV;
        cmd_chan   = 2'h0;
        res_ready  = 1'b0;
        n_fail     = 0;
        n_compared = 0;
        for (int k = 0; k < 4; k++) begin
            analog_code[k] = 12'h000;
        end
        repeat (10) @(posedge clk);
        chk("busy_n in reset", 12'h001, {11'h000, u_sapi_if.busy_n});
        chk("data_oe_n in reset", 12'h001, {11'h000, u_sapi_if.data_oe_n});
        chk("res_valid in reset", 12'h000, {11'h000, res_valid});
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_codes();
        test_buffer();
        test_power();
        test_done();
    end

endmodule : tb_top

`default_nettype wire
